// ==== design/tcr_pkg.sv ====
// package for the timer control and reload block
// assumes an sfr-style byte access port with one-cycle read/write strobes
//
// Function
// - high byte rolling from ff to 00 sets the high overflow flag
// - in 16-bit mode a ffff to 0000 wrap sets the high overflow flag
// - high overflow flag set raises interrupt when core timer interrupt enabled
// - overflow flags are never cleared by hardware, only by software writes
// - low byte rollover sets the low overflow flag in every mode
// - low overflow with low irq enable and core enable requests interrupt
// - capture enable: capture event copies count to reload pair and interrupts
// - split bit 0 gives one 16-bit auto-reload, 1 gives two 8-bit
// - run control gates counting; in split mode only the high byte
// - select 00, 10, 11 choose external clock and capture trigger sources
// - in split mode select applies to both bytes, per-byte choice still applies
// - external clock sources are synchronised to the system clock before use
// - reload low byte is loaded into count low byte in auto-reload
// - in capture mode reload low byte holds captured count low byte
// - reload high byte holds reload or captured high byte
// - count bytes form 16-bit count, or two independent 8-bit counts
package tcr_pkg;
    localparam logic [7:0] TCR_CTRL_ADDR = 8'h91;
    localparam logic [7:0] TCR_RLL_ADDR = 8'h92;
    localparam logic [7:0] TCR_RLH_ADDR = 8'h93;
    localparam logic [7:0] TCR_CNTL_ADDR = 8'h94;
    localparam logic [7:0] TCR_CNTH_ADDR = 8'h95;
    localparam logic [7:0] TCR_CTRL_RESET = 8'h00;
    localparam logic [7:0] TCR_RL_RESET = 8'h00;
    localparam logic [7:0] TCR_CNT_RESET = 8'h00;
    localparam int TCR_HOF_BIT = 7;
    localparam int TCR_LOF_BIT = 6;
    localparam int TCR_LIE_BIT = 5;
    localparam int TCR_CAP_BIT = 4;
    localparam int TCR_SPLIT_BIT = 3;
    localparam int TCR_RUN_BIT = 2;
    localparam logic [3:0] TCR_DIV12_LAST = 4'hb;
    localparam logic [1:0] TCR_XSEL_SYS12_RTC = 2'h0;
    localparam logic [1:0] TCR_XSEL_SYS12_XO8 = 2'h2;
    localparam logic [1:0] TCR_XSEL_RTC_XO8 = 2'h3;

    // register access strobe from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcr_sfr_req_t;
endpackage

// ==== design/tcr_timer.sv ====
// timer control, reload and capture logic with its count bytes
// assumes rtc and external oscillator /8 arrive asynchronous as levels
`timescale 1ns/100ps
module tcr_timer (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access
    input wire tcr_pkg::tcr_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    // core side
    input wire logic core_timer_irq_enable,
    input wire logic high_byte_clock_choice,
    input wire logic low_byte_clock_choice,
    output logic timer_irq,
    // asynchronous clock sources
    input wire logic rtc_clk_in,
    input wire logic ext_osc_div8_in
);
    logic [7:0] ctrl_q;
    logic [7:0] rll_q;
    logic [7:0] rlh_q;
    logic [7:0] cntl_q;
    logic [7:0] cnth_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic [3:0] div_q;
    logic [2:0] rtc_sync_q;
    logic [2:0] xo_sync_q;
    logic rtc_lvl_q;
    logic xo_lvl_q;

    // three-stage synchronisers, change accepted when stages 2 and 3 agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rtc_sync_q <= 3'h0;
            xo_sync_q <= 3'h0;
        end else begin
            rtc_sync_q <= {rtc_sync_q[1:0], rtc_clk_in};
            xo_sync_q <= {xo_sync_q[1:0], ext_osc_div8_in};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rtc_lvl_q <= 1'b0;
            xo_lvl_q <= 1'b0;
        end else begin
            if (rtc_sync_q[1] == rtc_sync_q[2]) begin
                rtc_lvl_q <= rtc_sync_q[2];
            end
            if (xo_sync_q[1] == xo_sync_q[2]) begin
                xo_lvl_q <= xo_sync_q[2];
            end
        end
    end

    logic rtc_rise;
    logic xo_rise;
    assign rtc_rise = (rtc_sync_q[1] == rtc_sync_q[2]) && rtc_sync_q[2] && !rtc_lvl_q;
    assign xo_rise = (xo_sync_q[1] == xo_sync_q[2]) && xo_sync_q[2] && !xo_lvl_q;

    // system clock divided by 12
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= 4'h0;
        end else if (div_q == tcr_pkg::TCR_DIV12_LAST) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    logic div12_tick;
    assign div12_tick = (div_q == tcr_pkg::TCR_DIV12_LAST);

    // external clock and capture trigger select
    logic ext_tick;
    logic cap_tick;
    always_comb begin
        case (ctrl_q[1:0])
            tcr_pkg::TCR_XSEL_SYS12_XO8: begin
                ext_tick = div12_tick;
                cap_tick = xo_rise;
            end
            tcr_pkg::TCR_XSEL_RTC_XO8: begin
                ext_tick = rtc_rise;
                cap_tick = xo_rise;
            end
            default: begin
                ext_tick = div12_tick;
                cap_tick = rtc_rise;
            end
        endcase
    end

    logic split;
    logic run;
    logic cap_en;
    logic lo_tick;
    logic hi_tick;
    assign split = ctrl_q[tcr_pkg::TCR_SPLIT_BIT];
    assign run = ctrl_q[tcr_pkg::TCR_RUN_BIT];
    assign cap_en = ctrl_q[tcr_pkg::TCR_CAP_BIT];
    // per-byte choice between external tick and system clock
    assign lo_tick = low_byte_clock_choice ? 1'b1 : ext_tick;
    assign hi_tick = high_byte_clock_choice ? 1'b1 : ext_tick;

    logic lo_inc;
    logic hi_inc;
    logic lo_ovf;
    logic hi_ovf;
    logic cap_evt;
    always_comb begin
        if (split) begin
            lo_inc = lo_tick;
            hi_inc = run && hi_tick;
        end else begin
            lo_inc = run && lo_tick;
            hi_inc = 1'b0;
        end
        lo_ovf = lo_inc && (cntl_q == 8'hff);
        if (split) begin
            hi_ovf = hi_inc && (cnth_q == 8'hff);
        end else begin
            hi_ovf = lo_ovf && (cnth_q == 8'hff);
        end
        cap_evt = cap_en && cap_tick;
    end

    logic wr_ctrl;
    logic wr_rll;
    logic wr_rlh;
    logic wr_cntl;
    logic wr_cnth;
    assign wr_ctrl = sfr_req.wr && (sfr_req.addr == tcr_pkg::TCR_CTRL_ADDR);
    assign wr_rll = sfr_req.wr && (sfr_req.addr == tcr_pkg::TCR_RLL_ADDR);
    assign wr_rlh = sfr_req.wr && (sfr_req.addr == tcr_pkg::TCR_RLH_ADDR);
    assign wr_cntl = sfr_req.wr && (sfr_req.addr == tcr_pkg::TCR_CNTL_ADDR);
    assign wr_cnth = sfr_req.wr && (sfr_req.addr == tcr_pkg::TCR_CNTH_ADDR);

    // control register; flags set by hardware win over software clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= tcr_pkg::TCR_CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= sfr_req.wdata;
            end
            if (hi_ovf) begin
                ctrl_q[tcr_pkg::TCR_HOF_BIT] <= 1'b1;
            end
            if (lo_ovf) begin
                ctrl_q[tcr_pkg::TCR_LOF_BIT] <= 1'b1;
            end
        end
    end

    // reload pair, captured on capture events
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rll_q <= tcr_pkg::TCR_RL_RESET;
            rlh_q <= tcr_pkg::TCR_RL_RESET;
        end else if (cap_evt) begin
            rll_q <= cntl_q;
            rlh_q <= cnth_q;
        end else begin
            if (wr_rll) begin
                rll_q <= sfr_req.wdata;
            end
            if (wr_rlh) begin
                rlh_q <= sfr_req.wdata;
            end
        end
    end

    // count bytes with auto-reload; no reload while capturing
    // 16-bit mode: low byte only carries into the high byte until the full wrap
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cntl_q <= tcr_pkg::TCR_CNT_RESET;
        end else if (wr_cntl) begin
            cntl_q <= sfr_req.wdata;
        end else if ((split ? lo_ovf : hi_ovf) && !cap_en) begin
            cntl_q <= rll_q;
        end else if (lo_inc) begin
            cntl_q <= cntl_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnth_q <= tcr_pkg::TCR_CNT_RESET;
        end else if (wr_cnth) begin
            cnth_q <= sfr_req.wdata;
        end else if (hi_ovf && !cap_en) begin
            cnth_q <= rlh_q;
        end else if (split ? hi_inc : lo_ovf) begin
            cnth_q <= cnth_q + 8'h01;
        end
    end

    // interrupt request level follows the pending sources
    logic hof_now;
    logic lof_now;
    assign hof_now = ctrl_q[tcr_pkg::TCR_HOF_BIT] || hi_ovf;
    assign lof_now = (ctrl_q[tcr_pkg::TCR_LOF_BIT] || lo_ovf) && ctrl_q[tcr_pkg::TCR_LIE_BIT];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= core_timer_irq_enable && (hof_now || lof_now || cap_evt);
        end
    end
    assign timer_irq = irq_q;

    // registered read data
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (sfr_req.rd) begin
            case (sfr_req.addr)
                tcr_pkg::TCR_CTRL_ADDR: rdata_q <= ctrl_q;
                tcr_pkg::TCR_RLL_ADDR: rdata_q <= rll_q;
                tcr_pkg::TCR_RLH_ADDR: rdata_q <= rlh_q;
                tcr_pkg::TCR_CNTL_ADDR: rdata_q <= cntl_q;
                tcr_pkg::TCR_CNTH_ADDR: rdata_q <= cnth_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end
    assign sfr_rdata = rdata_q;
endmodule

// ==== verification/tb_timer_three_control_reload.sv ====
// self-checking bench for the timer block
// assumes the checker is bound alongside the design
`timescale 1ns/100ps
module tb_timer_three_control_reload;
    logic core_clk, rst, en, hs, ls, rtc, xo, irq;
    logic [7:0] rdata, v;
    tcr_pkg::tcr_sfr_req_t req;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    tcr_timer dut_u (.core_clk(core_clk), .rst(rst), .sfr_req(req), .sfr_rdata(rdata),
        .core_timer_irq_enable(en), .high_byte_clock_choice(hs),
        .low_byte_clock_choice(ls), .timer_irq(irq), .rtc_clk_in(rtc), .ext_osc_div8_in(xo));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude();
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = {1'b1, 1'b0, a, d};
        tick();
    endtask
    task automatic idle();
        req = '0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a);
        req = {1'b0, 1'b1, a, 8'h00};
        tick();
        idle();
        v = rdata;
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 12 && irq !== 1'b1; n++) begin
            tick();
        end
    endtask
    task automatic t_reset();
        for (int a = 8'h90; a < 8'h97; a++) begin
            rd(a[7:0]);
            chk(v, 8'h00);
        end
    endtask
    task automatic t_wrap16();
        en = 1'b1;
        wr(8'h92, 8'h34);
        wr(8'h93, 8'h12);
        wr(8'h94, 8'hff);
        wr(8'h95, 8'hff);
        wr(8'h91, 8'h04);
        wr(8'h91, 8'h00);
        rd(8'h95);
        chk(v, 8'h12);
        rd(8'h94);
        chk(v, 8'h34);
        rd(8'h91);
        chk(v, 8'hc0);
        chk({7'h00, irq}, 8'h01);
        repeat (20) tick();
        rd(8'h91);
        chk(v, 8'hc0);
        wr(8'h91, 8'h00);
        idle();
        idle();
        chk({7'h00, irq}, 8'h00);
    endtask
    task automatic t_split();
        wr(8'h92, 8'h80);
        wr(8'h94, 8'hfe);
        wr(8'h95, 8'h10);
        wr(8'h91, 8'h28);
        idle();
        wait_irq();
        chk({7'h00, irq}, 8'h01);
        wr(8'h91, 8'h60);
        rd(8'h95);
        chk(v, 8'h10);
        rd(8'h94);
        chk({7'h00, v[7]}, 8'h01);
        rd(8'h91);
        chk(v, 8'h60);
        wr(8'h91, 8'h00);
        idle();
    endtask
    task automatic t_capture();
        for (int c = 0; c < 4; c++) begin
            wr(8'h94, 8'h50 + c[7:0]);
            wr(8'h95, 8'ha0 + c[7:0]);
            wr(8'h91, 8'h10 | c[7:0]);
            idle();
            if (c < 2) rtc = 1'b1;
            else xo = 1'b1;
            wait_irq();
            chk({7'h00, irq}, 8'h01);
            rtc = 1'b0;
            xo = 1'b0;
            repeat (8) tick();
            rd(8'h92);
            chk(v, 8'h50 + c[7:0]);
            rd(8'h93);
            chk(v, 8'ha0 + c[7:0]);
        end
        wr(8'h91, 8'h00);
        idle();
    endtask
    task automatic t_ext();
        logic [7:0] w;
        ls = 1'b0;
        wr(8'h92, 8'h55);
        wr(8'h94, 8'hfe);
        wr(8'h95, 8'h00);
        wr(8'h91, 8'h07);
        idle();
        repeat (2) begin
            rtc = 1'b1;
            repeat (6) tick();
            rtc = 1'b0;
            repeat (6) tick();
        end
        rd(8'h94);
        chk(v, 8'h00);
        rd(8'h95);
        chk(v, 8'h01);
        rd(8'h91);
        chk(v, 8'h47);
        wr(8'h91, 8'h04);
        rd(8'h94);
        w = v;
        repeat (22) tick();
        rd(8'h94);
        chk(v, w + 8'h02);
        wr(8'h91, 8'h00);
        idle();
        ls = 1'b1;
    endtask
    initial begin
        rst = 1'b1;
        req = '0;
        en = 1'b0;
        hs = 1'b1;
        ls = 1'b1;
        rtc = 1'b0;
        xo = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_wrap16();
        t_split();
        t_capture();
        t_ext();
        conclude();
    end
endmodule

// ==== verification/tcr_timer_chk.sv ====
// port assertions for the timer block
// assumes it is bound to every tcr_timer instance
`timescale 1ns/100ps
module tcr_timer_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access
    input wire tcr_pkg::tcr_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    // core side
    input wire logic core_timer_irq_enable,
    input wire logic high_byte_clock_choice,
    input wire logic low_byte_clock_choice,
    input wire logic timer_irq,
    // clock sources
    input wire logic rtc_clk_in,
    input wire logic ext_osc_div8_in
);
    logic [5:0] ctl_q;
    logic ctl_wr;
    logic ctl_rd;
    assign ctl_wr = sfr_req.wr && sfr_req.addr == tcr_pkg::TCR_CTRL_ADDR;
    assign ctl_rd = sfr_req.rd && sfr_req.addr == tcr_pkg::TCR_CTRL_ADDR;
    // software copy of the plain control bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= 6'h00;
        end else if (ctl_wr) begin
            ctl_q <= sfr_req.wdata[5:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    irq_needs_en_a: assert property (!core_timer_irq_enable |=> !timer_irq)
        else $error("irq without core enable");
    rdata_hold_a: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    unmapped_zero_a: assert property (sfr_req.rd && (sfr_req.addr < 8'h91 ||
        sfr_req.addr > 8'h95) |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    ctrl_bits_a: assert property (ctl_rd |=> sfr_rdata[5:0] == $past(ctl_q))
        else $error("control bits wrong");
    flag_irq_a: assert property (ctl_rd && !ctl_wr && core_timer_irq_enable |=>
        !(sfr_rdata[7] || (sfr_rdata[6] && sfr_rdata[5])) || timer_irq) else $error("flag no irq");
    irq_persist_a: assert property (timer_irq && core_timer_irq_enable && !ctl_q[4] &&
        !ctl_wr && !$past(ctl_wr) |=> timer_irq) else $error("irq dropped by itself");
    irq_clear_a: assert property (ctl_wr && sfr_req.wdata == 8'h00 && ctl_q[4:2] == 3'h0
        |=> ##1 !timer_irq) else $error("irq stuck after clear");
    reset_idle_a: assert property ($fell(rst) |-> !timer_irq && sfr_rdata == 8'h00)
        else $error("not idle after reset");
    cover property (ctl_rd ##1 sfr_rdata[7]);
    cover property ($rose(timer_irq) && ctl_q[4]);
    cover property (ctl_rd ##1 sfr_rdata[6] && sfr_rdata[3]);
endmodule
bind tcr_timer tcr_timer_chk chk_u (.core_clk, .rst, .sfr_req, .sfr_rdata,
    .core_timer_irq_enable, .high_byte_clock_choice, .low_byte_clock_choice, .timer_irq,
    .rtc_clk_in, .ext_osc_div8_in);
